// >>> common/adc_regs.svh
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

`define ADC_ADDR_RESULT_A   16'hffb0
`define ADC_ADDR_RESULT_B   16'hffb2
`define ADC_ADDR_RESULT_C   16'hffb4
`define ADC_ADDR_RESULT_D   16'hffb6
`define ADC_ADDR_CTRL       16'hffb8

`define ADC_BIT_DONE        7
`define ADC_BIT_IE          6
`define ADC_BIT_START       5
`define ADC_BIT_SCAN        4
`define ADC_BIT_CKS         3
`define ADC_CH_MSB          2
`define ADC_CH_LSB          0

`define ADC_CTRL_RESET      8'h00
`define ADC_RESULT_RESET    16'h0000
`define ADC_RESULT_LSB      6

// conversion time in states, one state per clock
`define ADC_STATES_SLOW     134
`define ADC_STATES_FAST     70
`define ADC_CYC_W           8

`endif

// >>> common/adc_pkg.sv
// types shared by the converter control block
package adc_pkg;

    typedef enum logic [1:0] {
        ADC_IDLE,
        ADC_CONV,
        ADC_STORE
    } adc_state_t;

    // one processor byte access
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } adc_bus_req_t;

    // one finished conversion
    typedef struct packed {
        logic       valid;
        logic [1:0] chan;
        logic [9:0] value;
    } adc_result_t;

endpackage : adc_pkg

// >>> src/adc_conv_timer.sv
// conversion timer: counts states of one conversion and samples the converter code
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs.svh"

module adc_conv_timer
    import adc_pkg::*;
(
    input  wire logic                      mclk_i,
    input  wire logic                      resetn_i,
    input  wire logic                      start_i,
    input  wire logic                      abort_i,
    input  wire logic                      fast_i,
    input  wire logic [1:0]                chan_i,
    input  wire logic [9:0]                code_i,
    output var adc_result_t                result_o
);

    logic [`ADC_CYC_W-1:0] cnt_r;
    logic                  busy_r;
    logic [1:0]            chan_r;
    logic [`ADC_CYC_W-1:0] len_r;

    // length latched at start so a mid-conversion change cannot shorten it
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_r <= 1'b0;
            cnt_r  <= '0;
            chan_r <= 2'h0;
            len_r  <= '0;
        end else if (abort_i) begin
            busy_r <= 1'b0;
            cnt_r  <= '0;
        end else if (start_i && !busy_r) begin
            busy_r <= 1'b1;
            cnt_r  <= '0;
            chan_r <= chan_i;
            len_r  <= fast_i ? `ADC_CYC_W'(`ADC_STATES_FAST - 1) : `ADC_CYC_W'(`ADC_STATES_SLOW - 1);
        end else if (busy_r) begin
            cnt_r <= cnt_r + `ADC_CYC_W'(1);
            if (cnt_r == len_r) begin
                busy_r <= 1'b0;
            end
        end
    end

    // result pulse in the cycle after the last state of the conversion
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            result_o <= '0;
        end else begin
            result_o.valid <= busy_r && !abort_i && (cnt_r == len_r);
            result_o.chan  <= chan_r;
            result_o.value <= code_i;
        end
    end

endmodule : adc_conv_timer
`default_nettype wire

// >>> src/adc_ctrl.sv
// control/status register, result registers and sequencing of the converter
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs.svh"

module adc_ctrl
    import adc_pkg::*;
(
    input  wire logic                      mclk_i,
    input  wire logic                      resetn_i,
    input  wire logic                      standby_i,
    input  wire logic                      bus_rd_i,
    input  wire logic                      bus_wr_i,
    input  wire logic [15:0]               bus_addr_i,
    input  wire logic [7:0]                bus_wdata_i,
    input  wire logic [9:0]                conv_code_i,
    output logic      [7:0]                bus_rdata_o,
    output logic      [2:0]                conv_chan_o,
    output logic                           conv_sample_o,
    output logic                           conv_end_request_o
);

    adc_bus_req_t   req;
    adc_result_t    res;
    adc_state_t     state_r;
    logic [9:0]     result_r [4];
    logic [7:0]     temp_low_r;
    logic           done_r;
    logic           done_seen_r;
    logic           ie_r;
    logic           start_r;
    logic           scan_r;
    logic           cks_r;
    logic [2:0]     chan_sel_r;
    logic [1:0]     cur_chan_r;
    logic           kick;
    logic           abort;
    logic           ctrl_wr;
    logic           ctrl_rd;
    logic           last_chan;
    logic [7:0]     ctrl_val;
    logic [7:0]     rdata_nxt;
    logic           standby_s1_r;
    logic           standby_s2_r;

    assign req.rd    = bus_rd_i;
    assign req.wr    = bus_wr_i;
    assign req.addr  = bus_addr_i;
    assign req.wdata = bus_wdata_i;

    // standby comes from outside this clock domain
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            standby_s1_r <= 1'b0;
            standby_s2_r <= 1'b0;
        end else begin
            standby_s1_r <= standby_i;
            standby_s2_r <= standby_s1_r;
        end
    end

    assign ctrl_wr   = req.wr && (req.addr == `ADC_ADDR_CTRL);
    assign ctrl_rd   = req.rd && (req.addr == `ADC_ADDR_CTRL);
    assign abort     = standby_s2_r || !start_r;
    // scan ends its pass at the highest selected channel; codes above 3 clamp to 3
    assign last_chan = !scan_r || (cur_chan_r == (chan_sel_r[2] ? 2'h3 : chan_sel_r[1:0]));
    assign ctrl_val  = {done_r, ie_r, start_r, scan_r, cks_r, chan_sel_r};

    // control bits; hardware start clear loses to a same-cycle software start
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ie_r       <= 1'b0;
            start_r    <= 1'b0;
            scan_r     <= 1'b0;
            cks_r      <= 1'b0;
            chan_sel_r <= 3'h0;
        end else begin
            if (ctrl_wr) begin
                ie_r       <= req.wdata[`ADC_BIT_IE];
                scan_r     <= req.wdata[`ADC_BIT_SCAN];
                cks_r      <= req.wdata[`ADC_BIT_CKS];
                chan_sel_r <= req.wdata[`ADC_CH_MSB:`ADC_CH_LSB];
            end
            if (ctrl_wr) begin
                start_r <= req.wdata[`ADC_BIT_START];
            end else if (standby_s2_r) begin
                start_r <= 1'b0;
            end else if (res.valid && !scan_r) begin
                start_r <= 1'b0;
            end
        end
    end

    // done flag: set wins over a same-cycle clear
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            done_r      <= 1'b0;
            done_seen_r <= 1'b0;
        end else begin
            if (res.valid && last_chan) begin
                done_r <= 1'b1;
            end else if (ctrl_wr && !req.wdata[`ADC_BIT_DONE] && done_seen_r) begin
                done_r <= 1'b0;
            end
            if (ctrl_rd && done_r) begin
                done_seen_r <= 1'b1;
            end else if (ctrl_wr) begin
                done_seen_r <= 1'b0;
            end
        end
    end

    // sequencer: one channel in single mode, ascending sweep in scan mode
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r    <= ADC_IDLE;
            cur_chan_r <= 2'h0;
        end else begin
            unique case (state_r)
                ADC_IDLE: begin
                    if (start_r && !standby_s2_r) begin
                        state_r    <= ADC_CONV;
                        cur_chan_r <= scan_r ? 2'h0 : chan_sel_r[1:0];
                    end
                end
                ADC_CONV: begin
                    if (abort) begin
                        state_r <= ADC_IDLE;
                    end else if (res.valid) begin
                        state_r <= ADC_STORE;
                    end
                end
                ADC_STORE: begin
                    if (abort || !scan_r) begin
                        state_r <= ADC_IDLE;
                    end else begin
                        state_r    <= ADC_CONV;
                        cur_chan_r <= last_chan ? 2'h0 : cur_chan_r + 2'h1;
                    end
                end
            endcase
        end
    end

    // start held for the whole conversion state except the result cycle, which must not relaunch the timer with a stale channel
    assign kick = (state_r == ADC_CONV) && !res.valid;

    adc_conv_timer u_timer (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .start_i  (kick),
        .abort_i  (abort),
        .fast_i   (cks_r),
        .chan_i   (cur_chan_r),
        .code_i   (conv_code_i),
        .result_o (res)
    );

    // result store per channel, one generate entry each
    for (genvar i = 0; i < 4; i++) begin : g_res
        always_ff @(posedge mclk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                result_r[i] <= 10'h000;
            end else if (res.valid && res.chan == 2'(i)) begin
                result_r[i] <= res.value;
            end
        end
    end

    // read mux; writes to result addresses fall through untouched
    always_comb begin
        rdata_nxt = 8'h00;
        unique case (req.addr)
            `ADC_ADDR_CTRL:         rdata_nxt = ctrl_val;
            `ADC_ADDR_RESULT_A:     rdata_nxt = result_r[0][9:2];
            `ADC_ADDR_RESULT_B:     rdata_nxt = result_r[1][9:2];
            `ADC_ADDR_RESULT_C:     rdata_nxt = result_r[2][9:2];
            `ADC_ADDR_RESULT_D:     rdata_nxt = result_r[3][9:2];
            `ADC_ADDR_RESULT_A + 16'h0001,
            `ADC_ADDR_RESULT_B + 16'h0001,
            `ADC_ADDR_RESULT_C + 16'h0001,
            `ADC_ADDR_RESULT_D + 16'h0001: rdata_nxt = temp_low_r;
            default:                rdata_nxt = 8'h00;
        endcase
    end

    // high-byte read captures low byte so a word read stays coherent
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            temp_low_r <= 8'h00;
        end else if (req.rd && !req.addr[0] && req.addr >= `ADC_ADDR_RESULT_A
                     && req.addr <= `ADC_ADDR_RESULT_D) begin
            temp_low_r <= {result_r[req.addr[2:1]][1:0], 6'h00};
        end
    end

    // registered outputs
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bus_rdata_o        <= 8'h00;
            conv_chan_o        <= 3'h0;
            conv_sample_o      <= 1'b0;
            conv_end_request_o <= 1'b0;
        end else begin
            bus_rdata_o        <= req.rd ? rdata_nxt : 8'h00;
            conv_chan_o        <= {1'b0, cur_chan_r};
            conv_sample_o      <= kick && !abort;
            conv_end_request_o <= done_r && ie_r;
        end
    end

endmodule : adc_ctrl
`default_nettype wire

// >>> testbench/adc_ctrl_assertions.sv
// port checks of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_chk (
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    input  wire logic        standby_i,
    input  wire logic        bus_rd_i,
    input  wire logic        bus_wr_i,
    input  wire logic [15:0] bus_addr_i,
    input  wire logic [7:0]  bus_wdata_i,
    input  wire logic [9:0]  conv_code_i,
    input  wire logic [7:0]  bus_rdata_o,
    input  wire logic [2:0]  conv_chan_o,
    input  wire logic        conv_sample_o,
    input  wire logic        conv_end_request_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    logic lo_rd;
    logic mapped;
    // result window is 0xffb0..0xffb7, control sits alone at 0xffb8
    assign lo_rd  = bus_rd_i && bus_addr_i[15:3] == 13'h1ff6 && bus_addr_i[0];
    assign mapped = bus_addr_i[15:3] == 13'h1ff6 || bus_addr_i == 16'hffb8;

    a_low_zero: assert property (lo_rd |=> bus_rdata_o[5:0] == 6'h00)
        else $error("low result bits not zero");
    a_idle_rdata: assert property (!bus_rd_i |=> bus_rdata_o == 8'h00)
        else $error("read data without a read");
    a_unmapped_zero: assert property (bus_rd_i && !mapped |=> bus_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_chan_range: assert property (conv_sample_o |-> conv_chan_o <= 3'h3)
        else $error("channel out of range");
    a_conv_min: assert property ($rose(conv_sample_o) |-> conv_sample_o [*8])
        else $error("conversion too short");
    a_conv_max: assert property ($rose(conv_sample_o) |-> ##[1:140] !conv_sample_o)
        else $error("conversion too long");
    a_standby_stop: assert property (standby_i [*6] |=> !conv_sample_o)
        else $error("standby did not stop conversion");
    a_req_quiet: assert property ((!bus_wr_i && !conv_sample_o) [*4] |=> $stable(conv_end_request_o))
        else $error("request moved without cause");
endmodule : adc_chk

bind adc_ctrl adc_chk u_chk (.mclk_i(mclk_i), .resetn_i(resetn_i), .standby_i(standby_i),
    .bus_rd_i(bus_rd_i), .bus_wr_i(bus_wr_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
    .conv_code_i(conv_code_i), .bus_rdata_o(bus_rdata_o), .conv_chan_o(conv_chan_o),
    .conv_sample_o(conv_sample_o), .conv_end_request_o(conv_end_request_o));
`default_nettype wire

// >>> testbench/adc_analog_model.sv
// analogue source model: one level per channel, scrambled outside a conversion
`timescale 1ns/1ps
`default_nettype none
module adc_analog_model (
    input  wire logic [2:0] chan_i,
    input  wire logic       sample_i,
    input  wire logic [9:0] bias_i,
    output logic      [9:0] code_o
);
    logic [9:0] level;
    // idle code inverted so a sample taken at the wrong time shows
    assign level  = {chan_i[1:0], 6'h2d, chan_i[1:0]} ^ bias_i;
    assign code_o = sample_i ? level : ~level;
endmodule : adc_analog_model
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        mclk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        standby_i = 1'b0;
    logic        bus_rd_i = 1'b0;
    logic        bus_wr_i = 1'b0;
    logic [15:0] bus_addr_i = 16'h0000;
    logic [7:0]  bus_wdata_i = 8'h00;
    logic [9:0]  bias = 10'h000;
    logic [9:0]  conv_code_i;
    logic [7:0]  bus_rdata_o;
    logic [7:0]  rd_q;
    logic [2:0]  conv_chan_o;
    logic        conv_sample_o;
    logic        conv_end_request_o;
    int          err_total = 0;
    int          n_compared = 0;

    initial forever #2.5 mclk_i = ~mclk_i;

    adc_ctrl dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .standby_i(standby_i), .bus_rd_i(bus_rd_i),
        .bus_wr_i(bus_wr_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .conv_code_i(conv_code_i),
        .bus_rdata_o(bus_rdata_o), .conv_chan_o(conv_chan_o), .conv_sample_o(conv_sample_o),
        .conv_end_request_o(conv_end_request_o));
    adc_analog_model u_ana (.chan_i(conv_chan_o), .sample_i(conv_sample_o), .bias_i(bias), .code_o(conv_code_i));

    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : cmp8

    // every access starts just after a rising edge and holds one cycle
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus_wr_i <= 1'b1;
        bus_addr_i <= a;
        bus_wdata_i <= d;
        @(posedge mclk_i);
        bus_wr_i <= 1'b0;
        @(posedge mclk_i);
    endtask : wr

    task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
        bus_rd_i <= 1'b1;
        bus_addr_i <= a;
        @(posedge mclk_i);
        bus_rd_i <= 1'b0;
        #1 rd_q = bus_rdata_o;
        cmp8($sformatf("read %h", a), exp, rd_q);
        @(posedge mclk_i);
    endtask : rchk

    // level the analogue model presents for a channel and bias
    function automatic logic [9:0] lvl(input logic [1:0] ch, input logic [9:0] b);
        return {ch, 6'h2d, ch} ^ b;
    endfunction : lvl

    // high byte first, as the processor must
    task automatic rres(input logic [1:0] ch, input logic [9:0] v);
        rchk(16'hffb0 + {13'h0000, ch, 1'b0}, v[9:2]);
        rchk(16'hffb1 + {13'h0000, ch, 1'b0}, {v[1:0], 6'h00});
    endtask : rres

    task automatic wait_req;
        // a full scan pass of four slow conversions needs about 550 cycles
        for (int i = 0; i < 700 && conv_end_request_o !== 1'b1; i++) begin
            @(posedge mclk_i);
            #1;
        end
        cmp8("request", 8'h01, {7'h00, conv_end_request_o});
        @(posedge mclk_i);
    endtask : wait_req

    task automatic t_reset;
        for (int c = 0; c < 4; c++) rres(c[1:0], 10'h000);
        rchk(16'hffb8, 8'h00);
    endtask : t_reset

    task automatic t_single;
        for (int c = 0; c < 4; c++) begin
            wr(16'hffb8, {4'b0110, c[0], 1'b0, c[1:0]});
            wait_req;
            rchk(16'hffb8, {4'b1100, c[0], 1'b0, c[1:0]});
            wr(16'hffb8, 8'h40);
            @(posedge mclk_i);
            cmp8("request", 8'h00, {7'h00, conv_end_request_o});
            rres(c[1:0], lvl(c[1:0], 10'h000));
        end
    endtask : t_single

    // a zero write without a prior read of one must not clear
    task automatic t_noclear;
        wr(16'hffb8, 8'h20);
        repeat (200) @(posedge mclk_i);
        cmp8("request", 8'h00, {7'h00, conv_end_request_o});
        wr(16'hffb8, 8'h00);
        rchk(16'hffb8, 8'h80);
        wr(16'hffb8, 8'h00);
        rchk(16'hffb8, 8'h00);
    endtask : t_noclear

    task automatic t_readonly;
        wr(16'hffb0, 8'hff);
        wr(16'hffb1, 8'hff);
        rres(2'd0, lvl(2'd0, 10'h000));
        rchk(16'hffba, 8'h00);
        rchk(16'hffb0, 8'h2d);
        rchk(16'hffb2, 8'h6d);
        rchk(16'hffb1, 8'h40);
    endtask : t_readonly

    task automatic t_scan;
        bias <= 10'h3ff;
        wr(16'hffb8, 8'h73);
        wait_req;
        rchk(16'hffb8, 8'hf3);
        for (int c = 0; c < 4; c++) rres(c[1:0], lvl(c[1:0], 10'h3ff));
        wr(16'hffb8, 8'h43);
        repeat (150) @(posedge mclk_i);
        cmp8("sample", 8'h00, {7'h00, conv_sample_o});
        wr(16'hffb8, 8'h33);
        repeat (20) @(posedge mclk_i);
        standby_i <= 1'b1;
        repeat (10) @(posedge mclk_i);
        rchk(16'hffb8, 8'h13);
        standby_i <= 1'b0;
    endtask : t_scan

    initial begin
        repeat (4) @(posedge mclk_i);
        resetn_i <= 1'b1;
        @(posedge mclk_i);
        t_reset;
        t_single;
        t_noclear;
        t_readonly;
        t_scan;
        stop_test;
    end

    // hang guard, well beyond the longest expected run
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_total++;
        stop_test;
    end
endmodule : testbench
`default_nettype wire
